// *** verilog/bawc_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - opcode 24h plus immediate, one-cycle accumulate
// - carry add: accumulator, source, carry flag
// - carry from bit7, nibble carry bit3
// - overflow is carry6 xor carry7
// - source from register, direct, indirect, immediate
module bawc_top
    import bawc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       op_valid,
    input  wire logic [7:0] op_code,
    input  wire logic [1:0] op_kind,
    input  wire logic [3:0] src_sel,
    input  wire logic [7:0] src_reg,
    input  wire logic [7:0] src_dir,
    input  wire logic [7:0] src_ind,
    input  wire logic [7:0] src_imm,
    output logic      [7:0] acc,
    output logic            carry_flag,
    output logic            nibble_carry_flag,
    output logic            signed_overflow_flag,
    output logic            done
);
    typedef struct packed {
        logic [7:0] acc;
        logic       cy;
        logic       ac;
        logic       ov;
        logic       done;
    } bawc_state_t;

    bawc_state_t st_r;
    bawc_state_t st_nxt;
    bawc_add_if  add_p();
    logic        is_imm_add;
    logic        is_sum_with_carry_op;
    logic [7:0]  src_byte;

    bawc_adder u_adder (
        .p (add_p)
    );

    always_comb begin
        is_imm_add = op_valid && op_kind == BAWC_OP_ADD && op_code == BAWC_OPC_ADD_IMM;
        is_sum_with_carry_op    = op_valid && op_kind == BAWC_OP_SUM_WITH_CARRY_OP;
        unique case (src_sel)
            BAWC_SRC_REG: src_byte = src_reg;
            BAWC_SRC_DIR: src_byte = src_dir;
            BAWC_SRC_IND: src_byte = src_ind;
            BAWC_SRC_IMM: src_byte = src_imm;
            default:      src_byte = src_imm;
        endcase
        add_p.a   = st_r.acc;
        add_p.b   = is_imm_add ? src_imm : src_byte;
        add_p.cin = is_sum_with_carry_op ? st_r.cy : 1'b0;
    end

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (is_imm_add || is_sum_with_carry_op) begin
            st_nxt.acc  = add_p.sum;
            st_nxt.cy   = add_p.c7;
            st_nxt.ac   = add_p.c3;
            st_nxt.ov   = add_p.c6 ^ add_p.c7;
            st_nxt.done = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '{acc: BAWC_ACC_RST, cy: BAWC_FLAG_RST, ac: BAWC_FLAG_RST, ov: BAWC_FLAG_RST, done: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign acc                  = st_r.acc;
    assign carry_flag           = st_r.cy;
    assign nibble_carry_flag    = st_r.ac;
    assign signed_overflow_flag = st_r.ov;
    assign done                 = st_r.done;

    logic [8:0] ref_sum;
    assign ref_sum = {1'b0, st_r.acc} + {1'b0, add_p.b} + {8'h00, add_p.cin};

    logic       op_taken;
    logic [4:0] ref_nib;
    logic [7:0] ref_low7;
    assign op_taken = is_imm_add || is_sum_with_carry_op;
    assign ref_nib  = {1'b0, st_r.acc[3:0]} + {1'b0, add_p.b[3:0]} + {4'h0, add_p.cin};
    assign ref_low7 = {1'b0, st_r.acc[6:0]} + {1'b0, add_p.b[6:0]} + {7'h00, add_p.cin};

    // signed view: overflow means the true sum leaves the 8-bit signed range
    logic signed [8:0] sgn_sum;
    logic              sgn_ovf;
    assign sgn_sum = $signed({st_r.acc[7], st_r.acc}) + $signed({add_p.b[7], add_p.b}) + $signed({8'h00, add_p.cin});
    assign sgn_ovf = sgn_sum[8] ^ sgn_sum[7];

    imm_add_a: assert property (@(posedge clk) disable iff (!resetn)
        is_imm_add |=> done && acc == $past(st_r.acc) + $past(src_imm))
        else $error("immediate add result wrong");
    sum_with_carry_op_sum_a: assert property (@(posedge clk) disable iff (!resetn)
        is_sum_with_carry_op |=> acc == $past(ref_sum[7:0]))
        else $error("carry add result wrong");
    carry_out_a: assert property (@(posedge clk) disable iff (!resetn)
        (is_sum_with_carry_op || is_imm_add) |=> carry_flag == $past(ref_sum[8]))
        else $error("carry flag wrong");
    nibble_a: assert property (@(posedge clk) disable iff (!resetn)
        (is_sum_with_carry_op || is_imm_add) |=> nibble_carry_flag == $past(st_r.acc[3:0] + add_p.b[3:0] + add_p.cin > 5'h0f))
        else $error("nibble carry wrong");
    overflow_a: assert property (@(posedge clk) disable iff (!resetn)
        (is_sum_with_carry_op || is_imm_add) |=> signed_overflow_flag ==
            $past((st_r.acc[7] == add_p.b[7]) && (ref_sum[7] != st_r.acc[7])))
        else $error("overflow flag wrong");
    src_mux_a: assert property (@(posedge clk) disable iff (!resetn)
        (is_sum_with_carry_op && src_sel == BAWC_SRC_DIR) |-> add_p.b == src_dir)
        else $error("source select wrong");
    imm_cin_a: assert property (@(posedge clk) disable iff (!resetn)
        is_imm_add |-> add_p.cin == 1'b0)
        else $error("immediate add used carry");
    hold_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        !(is_sum_with_carry_op || is_imm_add) |=> !done && $stable(acc) && $stable(carry_flag))
        else $error("state changed while idle");

    // operand routing, adder reference, flag, refusal and done checks
    src_reg_a: assert property (@(posedge clk) disable iff (!resetn)
        (is_sum_with_carry_op && src_sel == BAWC_SRC_REG)
        |-> add_p.b == src_reg)
        else $error("register source not chosen");

    src_ind_a: assert property (@(posedge clk) disable iff (!resetn)
        (is_sum_with_carry_op && src_sel == BAWC_SRC_IND)
        |-> add_p.b == src_ind)
        else $error("indirect source not chosen");

    src_imm_a: assert property (@(posedge clk) disable iff (!resetn)
        (is_sum_with_carry_op && src_sel == BAWC_SRC_IMM)
        |-> add_p.b == src_imm)
        else $error("immediate source not chosen");

    src_dflt_a: assert property (@(posedge clk) disable iff (!resetn)
        (is_sum_with_carry_op && !(src_sel inside {BAWC_SRC_REG, BAWC_SRC_DIR, BAWC_SRC_IND, BAWC_SRC_IMM}))
        |-> add_p.b == src_imm)
        else $error("illegal source select not routed to immediate");

    imm_src_a: assert property (@(posedge clk) disable iff (!resetn)
        is_imm_add
        |-> add_p.b == src_imm)
        else $error("immediate add took wrong operand");

    sum_with_carry_op_cin_a: assert property (@(posedge clk) disable iff (!resetn)
        is_sum_with_carry_op
        |-> add_p.cin == st_r.cy)
        else $error("carry add ignored carry flag");

    sum_out_a: assert property (@(posedge clk) disable iff (!resetn)
        op_taken
        |-> add_p.sum == ref_sum[7:0])
        else $error("adder sum wrong");

    c7_out_a: assert property (@(posedge clk) disable iff (!resetn)
        op_taken
        |-> add_p.c7 == ref_sum[8])
        else $error("adder bit 7 carry wrong");

    c3_out_a: assert property (@(posedge clk) disable iff (!resetn)
        op_taken
        |-> add_p.c3 == ref_nib[4])
        else $error("adder bit 3 carry wrong");

    c6_out_a: assert property (@(posedge clk) disable iff (!resetn)
        op_taken
        |-> add_p.c6 == ref_low7[7])
        else $error("adder bit 6 carry wrong");

    ovf_sign_a: assert property (@(posedge clk) disable iff (!resetn)
        is_sum_with_carry_op
        |=> signed_overflow_flag == $past(sgn_ovf))
        else $error("overflow disagrees with signed sum");

    imm_nib_a: assert property (@(posedge clk) disable iff (!resetn)
        is_imm_add
        |=> nibble_carry_flag == $past(ref_nib[4]))
        else $error("immediate add nibble carry wrong");

    refuse_op_a: assert property (@(posedge clk) disable iff (!resetn)
        (op_valid && op_kind == BAWC_OP_ADD && op_code != BAWC_OPC_ADD_IMM)
        |=> !done && $stable(acc))
        else $error("wrong opcode was executed");

    kind_bad_a: assert property (@(posedge clk) disable iff (!resetn)
        (op_valid && op_kind != BAWC_OP_ADD && op_kind != BAWC_OP_SUM_WITH_CARRY_OP)
        |=> !done && $stable(acc))
        else $error("unknown kind was executed");

    flags_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        !op_taken
        |=> $stable(nibble_carry_flag) && $stable(signed_overflow_flag))
        else $error("flags changed while idle");

    done_one_a: assert property (@(posedge clk) disable iff (!resetn)
        op_taken
        |=> done)
        else $error("no done after accepted op");

    done_low_a: assert property (@(posedge clk) disable iff (!resetn)
        !op_valid
        |=> !done)
        else $error("done without request");

    imm_ovf_a: assert property (@(posedge clk) disable iff (!resetn)
        is_imm_add
        |=> signed_overflow_flag == $past(sgn_ovf))
        else $error("immediate add overflow wrong");

    cov_imm: cover property (@(posedge clk) disable iff (!resetn) is_imm_add);
    cov_sum_with_carry_op_cy: cover property (@(posedge clk) disable iff (!resetn) is_sum_with_carry_op && st_r.cy);
    cov_ov: cover property (@(posedge clk) disable iff (!resetn) (is_sum_with_carry_op || is_imm_add) ##1 signed_overflow_flag);
    cov_ind: cover property (@(posedge clk) disable iff (!resetn) is_sum_with_carry_op && src_sel == BAWC_SRC_IND);
    cov_refuse: cover property (@(posedge clk) disable iff (!resetn) op_valid && !op_taken);
endmodule // bawc_top

// *** verilog/bawc_pkg.sv ***
package bawc_pkg;

    localparam int unsigned BAWC_W           = 8;
    localparam logic [7:0]  BAWC_OPC_ADD_IMM = 8'h24;
    localparam int unsigned BAWC_NIB_BIT     = 3;
    localparam int unsigned BAWC_SGN_BIT     = 6;
    localparam int unsigned BAWC_MSB_BIT     = 7;
    localparam logic [7:0]  BAWC_ACC_RST     = 8'h00;
    localparam logic        BAWC_FLAG_RST    = 1'h0;

    typedef enum logic [3:0] {
        BAWC_SRC_REG = 4'h1,
        BAWC_SRC_DIR = 4'h2,
        BAWC_SRC_IND = 4'h4,
        BAWC_SRC_IMM = 4'h8
    } bawc_src_t;

    typedef enum logic [1:0] {
        BAWC_OP_ADD  = 2'h1,
        BAWC_OP_SUM_WITH_CARRY_OP = 2'h2
    } bawc_op_t;

endpackage

// *** verilog/bawc_add_if.sv ***
`timescale 1ns/1ps
interface bawc_add_if;
    import bawc_pkg::*;
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic [7:0] sum;
    logic       c3;
    logic       c6;
    logic       c7;
    modport user (output a, output b, output cin, input sum, input c3, input c6, input c7);
    modport adder (input a, input b, input cin, output sum, output c3, output c6, output c7);
endinterface

// *** verilog/bawc_adder.sv ***
`timescale 1ns/1ps
module bawc_adder
    import bawc_pkg::*;
(
    bawc_add_if.adder p
);
    logic [4:0] lo;
    logic [3:0] mid;
    logic [1:0] hi;

    // split sum exposes carry-outs of bits 3, 6 and 7
    always_comb begin
        lo    = {1'b0, p.a[3:0]} + {1'b0, p.b[3:0]} + {4'h0, p.cin};
        mid   = {1'b0, p.a[6:4]} + {1'b0, p.b[6:4]} + {3'h0, lo[4]};
        hi    = {1'b0, p.a[7]} + {1'b0, p.b[7]} + {1'b0, mid[3]};
        p.sum = {hi[0], mid[2:0], lo[3:0]};
        p.c3  = lo[4];
        p.c6  = mid[3];
        p.c7  = hi[1];
    end
endmodule // bawc_adder

// *** dv/bawc_bench.sv ***
`timescale 1ns/1ps
`define CHK(n,e,s) begin num_checks++; if ((e) !== (s)) begin bad_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module bawc_bench;
    import bawc_pkg::*;
    logic       clk = 1'b0, resetn = 1'b0, op_valid = 1'b0, m_cy = 1'b0;
    logic [7:0] op_code = 8'h00, src_reg = 8'h00, src_dir = 8'h00, src_ind = 8'h00, src_imm = 8'h00;
    logic [7:0] acc, m_acc = 8'h00;
    logic [1:0] op_kind = 2'h0;
    logic [3:0] src_sel = 4'h1;
    logic       carry_flag, nibble_carry_flag, signed_overflow_flag, done;
    int         bad_count = 0, num_checks = 0;
    bawc_top dut (.clk(clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code), .op_kind(op_kind),
        .src_sel(src_sel), .src_reg(src_reg), .src_dir(src_dir), .src_ind(src_ind), .src_imm(src_imm),
        .acc(acc), .carry_flag(carry_flag), .nibble_carry_flag(nibble_carry_flag),
        .signed_overflow_flag(signed_overflow_flag), .done(done));
    initial forever #25 clk = ~clk;
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one request; b goes on src_imm for an immediate add, else on the sel source; all other source bytes hold the inverse
    task op(input logic [1:0] k, input logic [7:0] oc, input logic [3:0] sel, input logic [7:0] b, input logic take);
        logic       ci;
        logic [8:0] s9;
        logic [7:0] t7;
        logic [4:0] t4;
        ci = (k == 2'h2) ? m_cy : 1'b0;
        s9 = {1'b0, m_acc} + {1'b0, b} + {8'h00, ci};
        t7 = {1'b0, m_acc[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
        t4 = {1'b0, m_acc[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        @(negedge clk);
        {src_reg, src_dir, src_ind, src_imm} = {4{~b}};
        if (k == 2'h1 || sel == 4'h8) src_imm = b;
        else if (sel == 4'h1) src_reg = b;
        else if (sel == 4'h2) src_dir = b;
        else src_ind = b;
        op_kind = k;
        op_code = oc;
        src_sel = sel;
        op_valid = 1'b1;
        @(negedge clk);
        op_valid = 1'b0;
        `CHK("done", take, done)
        if (take) begin
            m_acc = s9[7:0];
            m_cy = s9[8];
            `CHK("nibble", t4[4], nibble_carry_flag)
            `CHK("ovf", t7[7] ^ s9[8], signed_overflow_flag)
        end
        `CHK("acc", m_acc, acc)
        `CHK("carry", m_cy, carry_flag)
    endtask
    task t_imm;
        op(2'h1, BAWC_OPC_ADD_IMM, 4'h1, 8'hc3, 1'b1);
        op(2'h1, BAWC_OPC_ADD_IMM, 4'h8, 8'h3d, 1'b1);
        op(2'h1, BAWC_OPC_ADD_IMM, 4'h2, 8'h7f, 1'b1);
        op(2'h1, BAWC_OPC_ADD_IMM, 4'h4, 8'h01, 1'b1);
        op(2'h1, BAWC_OPC_ADD_IMM, 4'h8, 8'h80, 1'b1);
        $display("test imm done");
    endtask
    task t_modes;
        logic [7:0] v [4] = '{8'haa, 8'hc3, 8'h7f, 8'hff};
        for (int i = 0; i < 4; i++) begin
            op(2'h2, 8'h00, 4'(1 << i), v[i], 1'b1);
        end
        $display("test modes done");
    endtask
    task t_refuse;
        op(2'h1, 8'h25, 4'h8, 8'h11, 1'b0);
        op(2'h3, BAWC_OPC_ADD_IMM, 4'h8, 8'h11, 1'b0);
        op(2'h0, BAWC_OPC_ADD_IMM, 4'h8, 8'h11, 1'b0);
        $display("test refuse done");
    endtask
    initial begin
        #(300 * 50);
        bad_count++;
        conclude;
    end
    initial begin
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        `CHK("rst acc", BAWC_ACC_RST, acc)
        t_imm;
        t_modes;
        t_refuse;
        conclude;
    end
endmodule // bawc_bench
